// ===== logic/pmp_status_pkg.sv
// Constants for the parallel slave buffer status block
package pmp_status_pkg;
   localparam int          NumBuf         = 4;
   localparam logic [11:0] AddrStatus     = 12'h000;
   localparam logic [11:0] AddrPadCfg     = 12'h004;
   localparam logic [11:0] AddrOutData    = 12'h008;
   localparam logic [11:0] AddrInData     = 12'h00C;
   localparam logic [11:0] AddrIrqStatus  = 12'h010;
   localparam logic [11:0] AddrIrqEnable  = 12'h014;
   localparam logic [11:0] AddrIrqClear   = 12'h018;
   localparam int          BitInFull      = 15;
   localparam int          BitInOvf       = 14;
   localparam int          BitInBufLo     = 8;
   localparam int          BitOutEmpty    = 7;
   localparam int          BitOutUnf      = 6;
   localparam int          BitOutBufLo    = 0;
   localparam logic [15:0] PadCfgMask     = 16'h0007;
   localparam logic [15:0] PadCfgReset    = 16'h0000;
   localparam logic [3:0]  PerBufOutReset = 4'hF;
   localparam int          IrqInOvf       = 0;
   localparam int          IrqOutUnf      = 1;
   localparam int          IrqInFull      = 2;
   localparam int          IrqOutEmpty    = 3;
endpackage

// ===== logic/byte_buffer.sv
// One byte buffer with a full flag, filled by one side and drained by the other
`timescale 1ns/10ps
`default_nettype none
module byte_buffer #(
   parameter int Width = 8
) (
   // Clock and reset
   input  wire logic             clk,
   input  wire logic             rst_n,
   // Fill side
   input  wire logic             fill,
   input  wire logic [Width-1:0] fillData,
   // Drain side
   input  wire logic             drain,
   // State
   output logic                  full,
   output logic [Width-1:0]      data
);
   logic             next_full;
   logic [Width-1:0] next_data;

   always_comb begin
      next_full = full;
      next_data = data;
      if (drain) begin
         next_full = 1'b0;
      end
      if (fill) begin
         next_full = 1'b1;
         next_data = fillData;
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         full <= 1'b0;
         data <= {Width{1'b0}};
      end else begin
         full <= next_full;
         data <= next_data;
      end
   end
endmodule
`default_nettype wire

// ===== logic/parallel_slave_buffer_status.sv
// Parallel slave port buffers, status flags and APB register access
`timescale 1ns/10ps
`default_nettype none
module parallel_slave_buffer_status
   import pmp_status_pkg::*;
(
   // Clock and reset
   input  wire logic        clk,
   input  wire logic        rst_n,
   // APB slave
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [11:0] paddr,
   input  wire logic [31:0] pwdata,
   output logic [31:0]      prdata,
   output logic             pready,
   output logic             pslverr,
   // Host parallel side
   input  wire logic        hostRead,
   input  wire logic        hostWrite,
   input  wire logic [1:0]  parallel_address_lines,
   input  wire logic [7:0]  hostWriteData,
   output logic [7:0]       hostReadData,
   // Pad configuration
   output logic [1:0]       seconds_clock_output_select,
   output logic             port_input_buffer_type_select,
   // Interrupt
   output logic             irq
);
   logic [NumBuf-1:0] inFull;
   logic [NumBuf-1:0] outFull;
   logic [7:0]        inData  [NumBuf];
   logic [7:0]        outData [NumBuf];
   logic [NumBuf-1:0] hostWrSel;
   logic [NumBuf-1:0] hostRdSel;
   logic [NumBuf-1:0] swInRead;
   logic [NumBuf-1:0] swOutWrite;
   logic [NumBuf-1:0] per_input_buffer_full_flags;
   logic [NumBuf-1:0] per_output_buffer_empty_flags;
   logic              all_inputs_full_flag;
   logic              all_outputs_empty_flag;
   logic              input_overflow_flag;
   logic              output_underflow_flag;
   logic              next_input_overflow_flag;
   logic              next_output_underflow_flag;
   logic [15:0]       statusWord;
   logic [15:0]       padCfg;
   logic [15:0]       next_padCfg;
   logic [3:0]        irqStatus;
   logic [3:0]        next_irqStatus;
   logic [3:0]        irqEnable;
   logic [3:0]        next_irqEnable;
   logic [3:0]        irqEvents;
   logic [31:0]       next_prdata;
   logic              next_pready;
   logic              next_pslverr;
   logic [7:0]        next_hostReadData;
   logic              access;
   logic              wrAccess;
   logic              rdAccess;
   logic              overflowEvent;
   logic              underflowEvent;
   logic              prevAllEmpty;
   logic              prevAllFull;
   logic              next_prevAllEmpty;
   logic              next_prevAllFull;
   logic              wrStatus;
   logic              wrPadCfg;
   logic              wrOutData;
   logic              wrIrqEnable;
   logic              wrIrqClear;
   logic              rdInData;
   logic [1:0]        swBufSel;
   logic              next_irq;
   logic [1:0]        next_secondsSel;
   logic              next_bufTypeSel;

   // One transfer per access phase; pready pulses for a single cycle
   assign access   = psel && penable && !pready;
   assign wrAccess = access && pwrite;
   assign rdAccess = access && !pwrite;

   // Register decode; input data reads name their buffer in pwdata
   assign swBufSel    = pwdata[9:8];
   assign wrStatus    = wrAccess && (paddr == AddrStatus);
   assign wrPadCfg    = wrAccess && (paddr == AddrPadCfg);
   assign wrOutData   = wrAccess && (paddr == AddrOutData);
   assign wrIrqEnable = wrAccess && (paddr == AddrIrqEnable);
   assign wrIrqClear  = wrAccess && (paddr == AddrIrqClear);
   assign rdInData    = rdAccess && (paddr == AddrInData);

   // Buffer decode from the host address
   always_comb begin
      for (int i = 0; i < NumBuf; i++) begin
         hostWrSel[i] = hostWrite && (parallel_address_lines == 2'(i));
         hostRdSel[i] = hostRead && (parallel_address_lines == 2'(i));
      end
   end

   // Buffer decode from the software buffer select
   always_comb begin
      for (int i = 0; i < NumBuf; i++) begin
         swInRead[i]   = rdInData && (swBufSel == 2'(i));
         swOutWrite[i] = wrOutData && (swBufSel == 2'(i));
      end
   end

   // Input buffers: host fills unless full, software drains
   for (genvar g = 0; g < NumBuf; g++) begin : gInBuf
      byte_buffer inBuf (
         .clk      (clk),
         .rst_n    (rst_n),
         .fill     (hostWrSel[g] && !inFull[g]),
         .fillData (hostWriteData),
         .drain    (swInRead[g]),
         .full     (inFull[g]),
         .data     (inData[g])
      );
   end

   // Output buffers: software fills, host drains
   for (genvar g = 0; g < NumBuf; g++) begin : gOutBuf
      byte_buffer outBuf (
         .clk      (clk),
         .rst_n    (rst_n),
         .fill     (swOutWrite[g]),
         .fillData (pwdata[7:0]),
         .drain    (hostRdSel[g]),
         .full     (outFull[g]),
         .data     (outData[g])
      );
   end

   assign per_input_buffer_full_flags   = inFull;
   assign per_output_buffer_empty_flags = ~outFull;
   assign all_inputs_full_flag          = &inFull;
   assign all_outputs_empty_flag        = ~|outFull;
   assign overflowEvent                 = |(hostWrSel & inFull);
   assign underflowEvent                = |(hostRdSel & ~outFull);

   // Status word from its field positions
   always_comb begin
      statusWord                       = 16'h0000;
      statusWord[BitInFull]            = all_inputs_full_flag;
      statusWord[BitInOvf]             = input_overflow_flag;
      statusWord[BitInBufLo +: NumBuf] = per_input_buffer_full_flags;
      statusWord[BitOutEmpty]          = all_outputs_empty_flag;
      statusWord[BitOutUnf]            = output_underflow_flag;
      statusWord[BitOutBufLo +: NumBuf] = per_output_buffer_empty_flags;
   end

   // Interrupt events; aggregate flags count on their rise only
   always_comb begin
      irqEvents              = 4'h0;
      irqEvents[IrqInOvf]    = overflowEvent;
      irqEvents[IrqOutUnf]   = underflowEvent;
      irqEvents[IrqInFull]   = all_inputs_full_flag && !prevAllFull;
      irqEvents[IrqOutEmpty] = all_outputs_empty_flag && !prevAllEmpty;
   end

   // Edge detectors reset to the flags' own reset levels
   always_comb begin
      next_prevAllEmpty = all_outputs_empty_flag;
      next_prevAllFull  = all_inputs_full_flag;
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         prevAllEmpty <= 1'b1;
         prevAllFull  <= 1'b0;
      end else begin
         prevAllEmpty <= next_prevAllEmpty;
         prevAllFull  <= next_prevAllFull;
      end
   end

   // Sticky flags; a hardware set wins over a software clear
   always_comb begin
      next_input_overflow_flag   = input_overflow_flag;
      next_output_underflow_flag = output_underflow_flag;
      if (wrStatus) begin
         if (!pwdata[BitInOvf]) begin
            next_input_overflow_flag = 1'b0;
         end
         if (!pwdata[BitOutUnf]) begin
            next_output_underflow_flag = 1'b0;
         end
      end
      if (overflowEvent) begin
         next_input_overflow_flag = 1'b1;
      end
      if (underflowEvent) begin
         next_output_underflow_flag = 1'b1;
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         input_overflow_flag   <= 1'b0;
         output_underflow_flag <= 1'b0;
      end else begin
         input_overflow_flag   <= next_input_overflow_flag;
         output_underflow_flag <= next_output_underflow_flag;
      end
   end

   // Pad configuration; only the writable bits are kept
   always_comb begin
      next_padCfg = padCfg;
      if (wrPadCfg) begin
         next_padCfg = pwdata[15:0] & PadCfgMask;
      end
      next_secondsSel = next_padCfg[2:1];
      next_bufTypeSel = next_padCfg[0];
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         padCfg                        <= PadCfgReset;
         seconds_clock_output_select   <= 2'b00;
         port_input_buffer_type_select <= 1'b0;
      end else begin
         padCfg                        <= next_padCfg;
         seconds_clock_output_select   <= next_secondsSel;
         port_input_buffer_type_select <= next_bufTypeSel;
      end
   end

   // Interrupt state; an event beats a clear in the same cycle
   always_comb begin
      next_irqEnable = irqEnable;
      next_irqStatus = irqStatus;
      if (wrIrqEnable) begin
         next_irqEnable = pwdata[3:0];
      end
      if (wrIrqClear) begin
         next_irqStatus = irqStatus & ~pwdata[3:0];
      end
      next_irqStatus = next_irqStatus | irqEvents;
      next_irq       = |(next_irqStatus & next_irqEnable);
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         irqEnable <= 4'h0;
         irqStatus <= 4'h0;
         irq       <= 1'b0;
      end else begin
         irqEnable <= next_irqEnable;
         irqStatus <= next_irqStatus;
         irq       <= next_irq;
      end
   end

   // APB read mux and answer
   always_comb begin
      next_prdata  = 32'h0000_0000;
      next_pslverr = 1'b0;
      next_pready  = access;
      if (access) begin
         unique case (paddr)
            AddrStatus:    next_prdata = {16'h0000, statusWord};
            AddrPadCfg:    next_prdata = {16'h0000, padCfg};
            AddrOutData:   next_prdata = 32'h0000_0000;
            AddrInData:    next_prdata = {24'h00_0000, inData[swBufSel]};
            AddrIrqStatus: next_prdata = {28'h000_0000, irqStatus};
            AddrIrqEnable: next_prdata = {28'h000_0000, irqEnable};
            AddrIrqClear:  next_prdata = 32'h0000_0000;
            default:       next_pslverr = 1'b1;
         endcase
      end
   end

   // Answer stands for one cycle only
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         prdata  <= 32'h0000_0000;
         pready  <= 1'b0;
         pslverr <= 1'b0;
      end else begin
         prdata  <= next_prdata;
         pready  <= next_pready;
         pslverr <= next_pslverr;
      end
   end

   // Host read data from the addressed output buffer
   always_comb begin
      next_hostReadData = hostReadData;
      if (hostRead) begin
         next_hostReadData = outData[parallel_address_lines];
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         hostReadData <= 8'h00;
      end else begin
         hostReadData <= next_hostReadData;
      end
   end
endmodule
`default_nettype wire

// ===== test/parallel_slave_buffer_status_assertions.sv
// Port checks for the parallel slave buffer status block
`timescale 1ns/10ps
`default_nettype none
module parallel_slave_buffer_status_assertions
   import pmp_status_pkg::*;
(
   // Clock and reset
   input wire logic        clk,
   input wire logic        rst_n,
   // APB
   input wire logic        psel,
   input wire logic        penable,
   input wire logic        pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] prdata,
   input wire logic        pready,
   input wire logic        pslverr,
   // Host side
   input wire logic        hostRead,
   input wire logic [7:0]  hostReadData
);
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_n);
   wire logic statRd = pready && psel && !pwrite && paddr == AddrStatus;
   AST_READY_AFTER_WAIT: assert property (psel && penable && !pready |=> pready)
      else $error("no pready after wait state");
   AST_READY_PULSE: assert property (pready |=> !pready)
      else $error("pready too long");
   AST_ERR_WITH_READY: assert property (pslverr |-> pready)
      else $error("pslverr without pready");
   AST_IDLE_RDATA: assert property (!pready |-> prdata == 32'h0000_0000)
      else $error("prdata not zero when idle");
   AST_ALL_EMPTY: assert property (statRd |-> prdata[7] == &prdata[3:0])
      else $error("all-empty flag wrong");
   AST_SOME_PENDING: assert property (statRd && !(&prdata[3:0]) |-> !prdata[7])
      else $error("all-empty set with data pending");
   AST_ALL_FULL: assert property (statRd |-> prdata[15] == &prdata[11:8])
      else $error("all-full flag wrong");
   AST_RESERVED_ZERO: assert property (statRd |-> prdata[31:16] == 16'h0000
      && prdata[13:12] == 2'b00 && prdata[5:4] == 2'b00)
      else $error("reserved status bits set");
   AST_HOST_DATA_HOLD: assert property (!hostRead |=> $stable(hostReadData))
      else $error("host read data moved");
endmodule
`default_nettype wire

// ===== test/host_port_model.sv
// Host processor model driving the parallel slave strobes
`timescale 1ns/10ps
`default_nettype none
module host_port_model (
   // Clock
   input  wire logic      clk,
   // Host strobes and bus
   output var logic       hostRead,
   output var logic       hostWrite,
   output var logic [1:0] parallel_address_lines,
   output var logic [7:0] hostWriteData
);
   initial begin
      hostRead = 1'b0;
      hostWrite = 1'b0;
      parallel_address_lines = 2'b00;
      hostWriteData = 8'h00;
   end
   // One byte per strobe; bus shows inverted value once released
   task automatic xfer(input logic w, input logic [1:0] a, input logic [7:0] d);
      parallel_address_lines <= a;
      hostWriteData <= d;
      hostWrite <= w;
      hostRead <= !w;
      @(posedge clk);
      hostWrite <= 1'b0;
      hostRead <= 1'b0;
      hostWriteData <= ~d;
      parallel_address_lines <= ~a;
      @(posedge clk);
   endtask
endmodule
`default_nettype wire

// ===== test/parallel_slave_buffer_status_tb.sv
// Self-checking bench for the parallel slave buffer status block
`timescale 1ns/10ps
`default_nettype none
`define CHK(g, e) begin num_checks++; if ((g) !== (e)) begin miscompares++; \
   $display("[FAIL] %0t got %h want %h", $time, (g), (e)); end end
module parallel_slave_buffer_status_tb
   import pmp_status_pkg::*;
;
   logic        clk = 1'b0, rst_n = 1'b0, err;
   logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0000_0000, prdata, rd;
   logic        pready, pslverr, hostRead, hostWrite, ttlSel, irq;
   logic [1:0]  addrLines, secSel;
   logic [7:0]  hostWriteData, hostReadData;
   int          miscompares = 0, num_checks = 0;
   always #4 clk = ~clk;
   parallel_slave_buffer_status u_parallel_slave_buffer_status (.clk(clk), .rst_n(rst_n),
      .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr), .hostRead(hostRead),
      .hostWrite(hostWrite), .parallel_address_lines(addrLines), .hostWriteData(hostWriteData),
      .hostReadData(hostReadData), .seconds_clock_output_select(secSel),
      .port_input_buffer_type_select(ttlSel), .irq(irq));
   host_port_model u_host_port_model (.clk(clk), .hostRead(hostRead), .hostWrite(hostWrite),
      .parallel_address_lines(addrLines), .hostWriteData(hostWriteData));
   task automatic end_sim();
      $display("checks %0d mismatches %0d", num_checks, miscompares);
      if (miscompares == 0 && num_checks > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      int n;
      n = 0;
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      do begin
         @(posedge clk);
         n++;
      end while (pready !== 1'b1 && n < 20);
      if (pready !== 1'b1) begin
         miscompares++;
         end_sim();
      end
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge clk);
   endtask
   task automatic chkRd(input logic [11:0] a, input logic [31:0] s, input logic [31:0] e);
      apb(1'b0, a, s);
      `CHK(rd, e)
   endtask
   initial begin
      repeat (2) @(posedge clk);
      rst_n <= 1'b1;
      @(posedge clk);
      chkRd(AddrStatus, 0, 32'h0000_008F);
      apb(1'b0, 12'h01C, 0);
      `CHK(err, 1'b1)
      $display("test reset done");
      for (int i = 0; i < 4; i++) begin
         u_host_port_model.xfer(1'b1, i[1:0], 8'hA0 + i[7:0]);
         chkRd(AddrStatus, 0, 32'h008F | (((32'h2 << i) - 1) << 8) | (i == 3 ? 32'h8000 : 0));
      end
      u_host_port_model.xfer(1'b1, 2'b10, 8'h55);
      chkRd(AddrStatus, 0, 32'h0000_CF8F);
      for (int i = 0; i < 4; i++) chkRd(AddrInData, i << 8, 32'hA0 + i);
      chkRd(AddrStatus, 0, 32'h0000_408F);
      apb(1'b1, AddrStatus, 0);
      chkRd(AddrStatus, 0, 32'h0000_008F);
      $display("test input done");
      apb(1'b1, AddrOutData, 32'h0000_013C);
      chkRd(AddrStatus, 0, 32'h0000_000D);
      u_host_port_model.xfer(1'b0, 2'b01, 8'h00);
      `CHK(hostReadData, 8'h3C)
      chkRd(AddrStatus, 0, 32'h0000_008F);
      u_host_port_model.xfer(1'b0, 2'b01, 8'h00);
      `CHK(hostReadData, 8'h3C)
      chkRd(AddrStatus, 0, 32'h0000_00CF);
      apb(1'b1, AddrStatus, 32'h0000_0040);
      chkRd(AddrStatus, 0, 32'h0000_00CF);
      apb(1'b1, AddrStatus, 0);
      chkRd(AddrStatus, 0, 32'h0000_008F);
      $display("test output done");
      chkRd(AddrIrqStatus, 0, 32'h0000_000F);
      `CHK(irq, 1'b0)
      apb(1'b1, AddrIrqEnable, 32'h0000_0002);
      repeat (2) @(posedge clk);
      `CHK(irq, 1'b1)
      apb(1'b1, AddrIrqClear, 32'h0000_000F);
      repeat (2) @(posedge clk);
      `CHK(irq, 1'b0)
      chkRd(AddrIrqStatus, 0, 32'h0000_0000);
      apb(1'b1, AddrPadCfg, 32'hFFFF_FFFF);
      chkRd(AddrPadCfg, 0, 32'h0000_0007);
      `CHK({secSel, ttlSel}, 3'b111)
      chkRd(AddrOutData, 0, 32'h0000_0000);
      apb(1'b1, 12'h01C, 32'h0000_0000);
      `CHK(err, 1'b1)
      chkRd(AddrPadCfg, 0, 32'h0000_0007);
      $display("test irq and pad done");
      u_host_port_model.xfer(1'b1, 2'b00, 8'h77);
      chkRd(AddrStatus, 0, 32'h0000_018F);
      rst_n <= 1'b0;
      repeat (2) @(posedge clk);
      rst_n <= 1'b1;
      @(posedge clk);
      `CHK({secSel, ttlSel, irq, hostReadData}, 12'h000)
      chkRd(AddrPadCfg, 0, 32'h0000_0000);
      chkRd(AddrStatus, 0, 32'h0000_008F);
      chkRd(AddrInData, 0, 32'h0000_0000);
      $display("test reset again done");
      end_sim();
   end
endmodule
bind parallel_slave_buffer_status parallel_slave_buffer_status_assertions u_chk (
   .clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
   .prdata(prdata), .pready(pready), .pslverr(pslverr), .hostRead(hostRead),
   .hostReadData(hostReadData));
`default_nettype wire
